// *** src/float_conversion_unit.sv ***
`timescale 1ns/1ns
module float_conversion_unit
(
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    // wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [3:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    // datapath
    input  wire logic [2:0]  OP_CODE,
    input  wire logic [31:0] A_BUS,
    input  wire logic        A_WIDE,
    output logic      [31:0] U_BUS,
    output logic             U_WIDE,
    output logic             U_VALID,
    // sequencer
    output logic             SEQ_FAULT,
    output logic             NO_INTERRUPT
);
    // ************************************************************
    // control register and bus
    // ************************************************************
    logic [31:0]            ctrl;
    fcu_pkg::bus_state_t    bus_state;
    logic                   wr_ctrl;
    logic                   wr_op;
    logic [31:0]            next_wdata;
    logic [3:0]             ev_flags;
    logic [7:0]             next_hexp;
    logic                   hexp_upd;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    assign wr_ctrl = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O
                     && WB_ADR_I == fcu_pkg::CTRL_OFFSET;
    assign wr_op   = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O
                     && WB_ADR_I == fcu_pkg::OPERAND_OFFSET;
    assign next_wdata = merge(ctrl, WB_DAT_I, WB_SEL_I);

    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            bus_state <= fcu_pkg::BUS_IDLE;
            WB_ACK_O  <= 1'b0;
            WB_DAT_O  <= 32'h0;
        end
        else
        begin
            case (bus_state)
                fcu_pkg::BUS_IDLE:
                begin
                    if (WB_CYC_I && WB_STB_I)
                    begin
                        bus_state <= fcu_pkg::BUS_ACK;
                        WB_ACK_O  <= 1'b1;
                        case (WB_ADR_I)
                            fcu_pkg::CTRL_OFFSET:   WB_DAT_O <= ctrl;
                            fcu_pkg::STATUS_OFFSET:
                                WB_DAT_O <= {30'h0, SEQ_FAULT, U_VALID};
                            fcu_pkg::OPERAND_OFFSET: WB_DAT_O <= U_BUS;
                            default:                WB_DAT_O <= 32'h0;
                        endcase
                    end
                end
                fcu_pkg::BUS_ACK:
                begin
                    bus_state <= fcu_pkg::BUS_IDLE;
                    WB_ACK_O  <= 1'b0;
                end
                default:
                begin
                    bus_state <= fcu_pkg::BUS_IDLE;
                    WB_ACK_O  <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // hidden exponent tracking
    // ************************************************************
    logic track_op;
    logic [8:0] prod_sum;
    assign track_op = OP_CODE == fcu_pkg::OP_PASS
                   || OP_CODE == fcu_pkg::OP_INT
                   || OP_CODE == fcu_pkg::OP_FIXED;
    assign prod_sum = 9'(ctrl[fcu_pkg::HEXP_LSB +: 8]) + A_BUS[31:23]
                      - fcu_pkg::EXP_BIAS_PROD;

    always_comb
    begin
        next_hexp = ctrl[fcu_pkg::HEXP_LSB +: 8];
        hexp_upd  = 1'b0;
        if (track_op)
        begin
            if (ctrl[fcu_pkg::PRODUCT_BIT])
            begin
                next_hexp = prod_sum[7:0];
                hexp_upd  = 1'b1;
            end
            else if (A_BUS[30:23] > ctrl[fcu_pkg::HEXP_LSB +: 8])
            begin
                next_hexp = A_BUS[30:23];
                hexp_upd  = 1'b1;
            end
        end
    end

    // flags: hardware set wins over a software clear
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            ctrl <= fcu_pkg::CTRL_RESET;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl <= next_wdata;
            end
            if (hexp_upd)
            begin
                ctrl[fcu_pkg::HEXP_LSB +: 8] <= next_hexp;
            end
            if (ev_flags[0])
            begin
                ctrl[fcu_pkg::INVALID_BIT] <= 1'b1;
            end
            if (ev_flags[1])
            begin
                ctrl[fcu_pkg::UNDERFLOW_BIT] <= 1'b1;
            end
            if (ev_flags[2])
            begin
                ctrl[fcu_pkg::OVERFLOW_BIT] <= 1'b1;
            end
            if (ev_flags[3])
            begin
                ctrl[fcu_pkg::FAULT_BIT] <= 1'b1;
            end
        end
    end

    // ************************************************************
    // stage one: capture operand
    // ************************************************************
    fcu_pkg::op_t s1_op;
    logic [31:0]  s1_a;
    logic [7:0]   s1_hexp;
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            s1_op        <= fcu_pkg::OP_NONE;
            s1_a         <= 32'h0;
            s1_hexp      <= 8'h00;
            NO_INTERRUPT <= 1'b0;
        end
        else
        begin
            s1_op <= fcu_pkg::op_t'(OP_CODE);
            s1_a  <= A_BUS;
            s1_hexp <= ctrl[fcu_pkg::HEXP_LSB +: 8];
            // hold off interrupts while a conversion is in flight
            NO_INTERRUPT <= OP_CODE >= fcu_pkg::OP_INT
                         && OP_CODE <= fcu_pkg::OP_SCALED;
        end
    end

    // ************************************************************
    // stage two: float to integer or fixed
    // ************************************************************
    logic [9:0]  pos;
    logic [31:0] mag;
    logic [31:0] to_int;
    logic        ti_ovf;
    logic        ti_unf;
    logic        is_nan;
    logic [7:0]  src_exp;
    assign is_nan  = s1_a[30:23] == 8'hff && s1_a[22:0] != 23'h0;
    // with use-hidden, for OP_FIXED only, the hidden exponent stands in for the operand's
    assign src_exp = ctrl[fcu_pkg::USE_HIDDEN_BIT]
                     && s1_op == fcu_pkg::OP_FIXED
                     ? s1_hexp : s1_a[30:23];
    always_comb
    begin
        pos = {2'b00, src_exp} - fcu_pkg::TO_INT_BIAS;
        if (s1_op == fcu_pkg::OP_FIXED)
        begin
            if (ctrl[fcu_pkg::TO_SCALED_BIT])
            begin
                pos = {{2{ctrl[7]}}, ctrl[fcu_pkg::TO_FIX_OFS_LSB +: 8]};
            end
            else
            begin
                pos = pos + {{2{ctrl[7]}}, ctrl[7:0]};
            end
        end
        ti_ovf = 1'b0;
        ti_unf = 1'b0;
        mag    = 32'h0;
        if (s1_a[30:0] == 31'h0)
        begin
            to_int = 32'h0;
        end
        else if (!pos[9] && pos > fcu_pkg::MSB_POS)
        begin
            ti_ovf = 1'b1;
            to_int = s1_a[31] ? 32'h8000_0000 : 32'h7fff_ffff;
        end
        else
        begin
            // leading bit at pos+1, mantissa below (0.1m format)
            mag = {8'h00, 1'b1, s1_a[22:0]};
            if (pos[9] && pos < 10'h3e8)
            begin
                mag = 32'h0;
            end
            else if (!pos[9] && pos >= 10'(fcu_pkg::MANT_TOP))
            begin
                mag = mag << (pos - 10'(fcu_pkg::MANT_TOP));
            end
            else
            begin
                mag = mag >> (10'(fcu_pkg::MANT_TOP) - pos);
            end
            ti_unf = mag == 32'h0;
            to_int = s1_a[31] ? 32'(-mag) : mag;
        end
    end

    // ************************************************************
    // stage two: integer or fixed to float
    // ************************************************************
    logic [31:0] to_flt;
    logic        tf_ovf;
    logic        tf_unf;
    fix_to_float u_fix_to_float
    (
        .operand     (s1_a),
        .offset      (ctrl[fcu_pkg::TO_FLT_OFS_LSB +: 8]),
        .use_offset  (s1_op == fcu_pkg::OP_SCALED),
        .replace_exp (ctrl[fcu_pkg::FROM_SCALED_BIT]),
        .use_hidden  (s1_op == fcu_pkg::OP_SCALED
                      && ctrl[fcu_pkg::USE_HIDDEN_BIT]),
        .hidden_exp  (s1_hexp),
        .result      (to_flt),
        .overflow    (tf_ovf),
        .underflow   (tf_unf)
    );

    always_comb
    begin
        ev_flags = 4'h0;
        if (s1_op == fcu_pkg::OP_INT || s1_op == fcu_pkg::OP_FIXED)
        begin
            ev_flags[0] = is_nan;
            ev_flags[1] = ti_unf && !is_nan;
            ev_flags[2] = ti_ovf || is_nan;
            ev_flags[3] = ti_ovf || is_nan;
        end
        else if (s1_op == fcu_pkg::OP_FLOAT || s1_op == fcu_pkg::OP_SCALED)
        begin
            ev_flags[1] = tf_unf;
            ev_flags[2] = tf_ovf;
            ev_flags[3] = tf_unf || tf_ovf;
        end
    end

    // ************************************************************
    // U register
    // ************************************************************
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            U_BUS     <= 32'h0;
            U_WIDE    <= 1'b0;
            U_VALID   <= 1'b0;
            SEQ_FAULT <= 1'b0;
        end
        else
        begin
            SEQ_FAULT <= ctrl[fcu_pkg::FAULT_BIT];
            U_VALID   <= 1'b0;
            if (s1_op == fcu_pkg::OP_INT || s1_op == fcu_pkg::OP_FIXED)
            begin
                U_BUS   <= to_int;
                U_WIDE  <= 1'b1;
                U_VALID <= 1'b1;
            end
            else if (s1_op == fcu_pkg::OP_FLOAT
                     || s1_op == fcu_pkg::OP_SCALED)
            begin
                U_BUS   <= to_flt;
                U_WIDE  <= 1'b1;
                U_VALID <= 1'b1;
            end
            else if (OP_CODE == fcu_pkg::OP_PASS)
            begin
                U_BUS   <= A_BUS;
                U_WIDE  <= A_WIDE;
                U_VALID <= 1'b1;
            end
            else if (wr_op)
            begin
                U_BUS <= WB_DAT_I;
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_pass_copy: assert property (@(posedge MCLK)
        disable iff (!RST_N) OP_CODE == fcu_pkg::OP_PASS
        && !(s1_op inside {[2:5]}) |=> U_BUS == $past(A_BUS) && U_VALID)
        else $error("pass result wrong");
    a_conv_latency: assert property (@(posedge MCLK)
        disable iff (!RST_N) OP_CODE == fcu_pkg::OP_INT
        && A_BUS[30:0] == 31'h0 |=> ##1 U_BUS == 32'h0 && U_VALID)
        else $error("zero conversion wrong");
    a_fault_seen: assert property (@(posedge MCLK)
        disable iff (!RST_N) ctrl[fcu_pkg::FAULT_BIT] |=> SEQ_FAULT)
        else $error("fault not forwarded");
    a_hexp_max: assert property (@(posedge MCLK)
        disable iff (!RST_N) track_op && !ctrl[fcu_pkg::PRODUCT_BIT]
        && !wr_ctrl |=> ctrl[23:16] >= $past(A_BUS[30:23]))
        else $error("hidden exponent not max");
    a_nan_flags: assert property (@(posedge MCLK)
        disable iff (!RST_N) s1_op == fcu_pkg::OP_INT && is_nan
        |=> ctrl[fcu_pkg::INVALID_BIT] && ctrl[fcu_pkg::FAULT_BIT])
        else $error("nan flags missing");
    a_unf_warn: assert property (@(posedge MCLK)
        disable iff (!RST_N) s1_op == fcu_pkg::OP_INT && ti_unf && !is_nan
        |-> !ev_flags[3] ##1 ctrl[fcu_pkg::UNDERFLOW_BIT])
        else $error("underflow raised fault");
    a_ovf_flags: assert property (@(posedge MCLK)
        disable iff (!RST_N) ev_flags[2]
        |=> ctrl[fcu_pkg::OVERFLOW_BIT] && ctrl[fcu_pkg::FAULT_BIT])
        else $error("overflow flags missing");
    a_flt_zero: assert property (@(posedge MCLK)
        disable iff (!RST_N) s1_op == fcu_pkg::OP_FLOAT && s1_a == 32'h0
        |=> U_BUS == 32'h0)
        else $error("float of zero wrong");
    c_pass: cover property (@(posedge MCLK) OP_CODE == fcu_pkg::OP_PASS);
    c_nan: cover property (@(posedge MCLK) ev_flags[0]);
    c_b2b: cover property (@(posedge MCLK)
        s1_op == fcu_pkg::OP_FLOAT && OP_CODE == fcu_pkg::OP_INT);
endmodule // float_conversion_unit

// *** inc/fcu_pkg.sv ***
package fcu_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [3:0]  CTRL_OFFSET      = 4'h0;
    localparam logic [3:0]  STATUS_OFFSET    = 4'h4;
    localparam logic [3:0]  OPCODE_OFFSET    = 4'h8;
    localparam logic [3:0]  OPERAND_OFFSET   = 4'hc;
    localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
    // ************************************************************
    // control register fields
    // ************************************************************
    localparam int TO_FIX_OFS_LSB = 0;
    localparam int TO_FLT_OFS_LSB = 8;
    localparam int HEXP_LSB       = 16;
    localparam int TO_SCALED_BIT  = 24;
    localparam int FROM_SCALED_BIT = 25;
    localparam int USE_HIDDEN_BIT = 26;
    localparam int PRODUCT_BIT    = 27;
    localparam int INVALID_BIT    = 28;
    localparam int UNDERFLOW_BIT  = 29;
    localparam int OVERFLOW_BIT   = 30;
    localparam int FAULT_BIT      = 31;
    // ************************************************************
    // number format
    // ************************************************************
    localparam logic [8:0] EXP_BIAS_PROD = 9'h07f;
    localparam logic [9:0] TO_INT_BIAS   = 10'h080;
    localparam logic [9:0] FROM_INT_BIAS = 10'h080;
    localparam logic [9:0] MSB_POS       = 10'h01d;
    localparam logic [4:0] MANT_TOP      = 5'h16;
    // ************************************************************
    // operations
    // ************************************************************
    typedef enum logic [2:0] {
        OP_NONE   = 3'h0,
        OP_PASS   = 3'h1,
        OP_INT    = 3'h2,
        OP_FIXED  = 3'h3,
        OP_FLOAT  = 3'h4,
        OP_SCALED = 3'h5
    } op_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK  = 2'b01
    } bus_state_t;
endpackage

// *** src/fix_to_float.sv ***
`timescale 1ns/1ns
// ************************************************************
// fixed or integer to float, combinational
// ************************************************************
module fix_to_float
(
    // operand and options
    input  wire logic [31:0] operand,
    input  wire logic [7:0]  offset,
    input  wire logic        use_offset,
    input  wire logic        replace_exp,
    input  wire logic        use_hidden,
    input  wire logic [7:0]  hidden_exp,
    // result
    output logic      [31:0] result,
    output logic             overflow,
    output logic             underflow
);
    logic [31:0] magnitude;
    logic [4:0]  lead;
    logic [31:0] shifted;
    logic [9:0]  exp_wide;

    always_comb
    begin
        magnitude = operand[31] ? 32'(-operand) : operand;
        lead = 5'h00;
        for (int i = 0; i < 32; i++)
        begin
            if (magnitude[i])
            begin
                lead = 5'(i);
            end
        end
        // leading one drops out as the hidden 0.1 bit
        // leading one lands on bit 23, so the field keeps what is below it
        if (lead > fcu_pkg::MANT_TOP)
        begin
            shifted = magnitude >> (lead - fcu_pkg::MANT_TOP - 5'h01);
        end
        else
        begin
            shifted = magnitude << (fcu_pkg::MANT_TOP + 5'h01 - lead);
        end
        // E sits one below the leading one
        exp_wide = 10'(lead) + fcu_pkg::FROM_INT_BIAS - 10'h001;
        if (use_offset)
        begin
            if (replace_exp)
            begin
                exp_wide = {{2{offset[7]}}, offset};
            end
            else
            begin
                exp_wide = exp_wide + {{2{offset[7]}}, offset};
            end
        end
        if (use_hidden)
        begin
            exp_wide = exp_wide + {2'b00, hidden_exp};
        end
        overflow  = 1'b0;
        underflow = 1'b0;
        if (magnitude == 32'h0)
        begin
            result = 32'h0;
        end
        else if (exp_wide[9])
        begin
            underflow = 1'b1;
            result    = 32'h0;
        end
        else if (exp_wide[8] || exp_wide[7:0] == 8'hff)
        begin
            overflow = 1'b1;
            result   = {operand[31], 8'hff, 23'h0};
        end
        else if (exp_wide[7:0] == 8'h00)
        begin
            underflow = 1'b1;
            result    = 32'h0;
        end
        else
        begin
            result = {operand[31], exp_wide[7:0], shifted[22:0]};
        end
    end
endmodule // fix_to_float

// *** bench/seq_model.sv ***
`timescale 1ns/1ns
// ****
// sequencer stand-in: one op per cycle from a short program
// ****
module seq_model
(
    // clock
    input  wire logic        clk,
    // operand buses
    output logic      [2:0]  op_code,
    output logic      [31:0] a_bus,
    output logic             a_wide
);
    logic [2:0]  prog_op [4];
    logic [31:0] prog_a  [4];
    logic        prog_w  [4];

    initial
    begin
        op_code = 3'h0;
        a_bus   = 32'h0;
        a_wide  = 1'b0;
    end

    // no gaps between ops, so conversions can overlap
    task automatic run(input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk);
            op_code <= prog_op[i];
            a_bus   <= prog_a[i];
            a_wide  <= prog_w[i];
        end
        @(posedge clk);
        op_code <= 3'h0;
        // idle bus shows the inverse, never a stale operand
        a_bus   <= ~a_bus;
        a_wide  <= ~a_wide;
    endtask
endmodule // seq_model

// *** bench/tb_float_conversion_unit.sv ***
`timescale 1ns/1ns
module tb_float_conversion_unit;
    typedef struct packed
    {
        logic [2:0]  op;
        logic [31:0] ctrl;
        logic [31:0] a;
        logic [31:0] u;
        logic [3:0]  flags;
        logic        chk;
    } row_t;

    logic        MCLK;
    logic        RST_N;
    logic        WB_CYC_I;
    logic        WB_STB_I;
    logic        WB_WE_I;
    logic [3:0]  WB_ADR_I;
    logic [3:0]  WB_SEL_I;
    logic [31:0] WB_DAT_I;
    logic [31:0] WB_DAT_O;
    logic        WB_ACK_O;
    logic [2:0]  OP_CODE;
    logic [31:0] A_BUS;
    logic        A_WIDE;
    logic [31:0] U_BUS;
    logic        U_WIDE;
    logic        U_VALID;
    logic        SEQ_FAULT;
    logic        NO_INTERRUPT;
    logic [31:0] rd;
    int          fail_count = 0;
    int          check_count = 0;
    int          cycles = 0;
    // ****
    // ordinary cases: op, ctrl, operand, result, flags 31..28, check u
    // ****
    row_t        rows [18] = '{
        '{3'h1, 32'h0, 32'h1234_5678, 32'h1234_5678, 4'h0, 1'b1},
        '{3'h2, 32'h0, 32'h4ac0_0000, 32'h0060_0000, 4'h0, 1'b1},
        '{3'h2, 32'h0, 32'h4e80_0000, 32'h4000_0000, 4'h0, 1'b1},
        '{3'h2, 32'h0, 32'h0, 32'h0, 4'h0, 1'b1},
        '{3'h2, 32'h0, 32'h3200_0000, 32'h0, 4'h2, 1'b1},
        '{3'h2, 32'h0, 32'h7fc0_0000, 32'h0, 4'hd, 1'b0},
        '{3'h2, 32'h0, 32'h4f00_0000, 32'h0, 4'hc, 1'b0},
        '{3'h3, 32'hf8, 32'h4ac0_0000, 32'h6000, 4'h0, 1'b1},
        '{3'h3, 32'h0100000d, 32'h4ac00000, 32'h6000, 4'h0, 1'b1},
        '{3'h3, 32'h4950000, 32'h800000, 32'h400000, 4'h0, 1'b1},
        '{3'h4, 32'h0, 32'h6, 32'h40c0_0000, 4'h0, 1'b1},
        '{3'h4, 32'h0, 32'hffff_fffa, 32'hc0c0_0000, 4'h0, 1'b1},
        '{3'h4, 32'h0, 32'h0, 32'h0, 4'h0, 1'b1},
        '{3'h5, 32'h0200, 32'h6, 32'h41c0_0000, 4'h0, 1'b1},
        '{3'h5, 32'h0402_0000, 32'h6, 32'h41c0_0000, 4'h0, 1'b1},
        '{3'h5, 32'h8000, 32'h1, 32'h0, 4'ha, 1'b1},
        '{3'h5, 32'h7f00, 32'h4000_0000, 32'h7f80_0000, 4'hc, 1'b1},
        '{3'h5, 32'h2000500, 32'h6, 32'h2c00000, 4'h0, 1'b1}
    };

    float_conversion_unit u_float_conversion_unit
    (
        .MCLK         (MCLK),
        .RST_N        (RST_N),
        .WB_CYC_I     (WB_CYC_I),
        .WB_STB_I     (WB_STB_I),
        .WB_WE_I      (WB_WE_I),
        .WB_ADR_I     (WB_ADR_I),
        .WB_SEL_I     (WB_SEL_I),
        .WB_DAT_I     (WB_DAT_I),
        .WB_DAT_O     (WB_DAT_O),
        .WB_ACK_O     (WB_ACK_O),
        .OP_CODE      (OP_CODE),
        .A_BUS        (A_BUS),
        .A_WIDE       (A_WIDE),
        .U_BUS        (U_BUS),
        .U_WIDE       (U_WIDE),
        .U_VALID      (U_VALID),
        .SEQ_FAULT    (SEQ_FAULT),
        .NO_INTERRUPT (NO_INTERRUPT)
    );

    seq_model u_seq_model
    (
        .clk     (MCLK),
        .op_code (OP_CODE),
        .a_bus   (A_BUS),
        .a_wide  (A_WIDE)
    );
    // ****
    // helpers
    // ****
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // single classic cycle; read data lands in rd
    task automatic wb(input logic we, input logic [3:0] adr,
                      input logic [31:0] wd);
        @(posedge MCLK);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I  <= we;
        WB_ADR_I <= adr;
        WB_SEL_I <= 4'hf;
        WB_DAT_I <= wd;
        do
            @(posedge MCLK);
        while (WB_ACK_O !== 1'b1);
        rd = WB_DAT_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
    endtask

    // one op, then one more edge so a conversion has landed too
    task automatic issue(input logic [2:0] op, input logic [31:0] a,
                         input logic w);
        u_seq_model.prog_op[0] = op;
        u_seq_model.prog_a[0] = a;
        u_seq_model.prog_w[0] = w;
        u_seq_model.run(1);
        @(posedge MCLK);
        #1;
    endtask

    initial
    begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end

    always @(posedge MCLK)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            fail_count++;
            final_report();
        end
    end
    // ****
    // main sequence
    // ****
    initial
    begin
        RST_N    = 1'b0;
        WB_CYC_I = 1'b0;
        WB_STB_I = 1'b0;
        WB_WE_I  = 1'b0;
        WB_ADR_I = 4'h0;
        WB_SEL_I = 4'h0;
        WB_DAT_I = 32'h0;
        repeat (4) @(posedge MCLK);
        RST_N <= 1'b1;
        @(posedge MCLK);
        #1;
        check(U_BUS, 32'h0);
        check({31'h0, SEQ_FAULT}, 32'h0);
        wb(1'b0, fcu_pkg::CTRL_OFFSET, 32'h0);
        check(rd, fcu_pkg::CTRL_RESET);
        // reserved place ignores writes and reads zero
        wb(1'b1, fcu_pkg::OPCODE_OFFSET, 32'hffff_ffff);
        wb(1'b0, fcu_pkg::OPCODE_OFFSET, 32'h0);
        check(rd, 32'h0);
        foreach (rows[i])
        begin
            wb(1'b1, 4'h0, rows[i].ctrl);
            issue(rows[i].op, rows[i].a, rows[i].op == 3'h1);
            if (rows[i].chk)
                check(U_BUS, rows[i].u);
            check({31'h0, U_WIDE}, 32'h1);
            wb(1'b0, 4'h0, 32'h0);
            check({28'h0, rd[31:28]}, {28'h0, rows[i].flags});
            check({31'h0, SEQ_FAULT}, {31'h0, rows[i].flags[3]});
        end
        // flags survive a later clean conversion
        wb(1'b1, 4'h0, 32'h0);
        issue(3'h2, 32'h7fc0_0000, 1'b0);
        issue(3'h2, 32'h4ac0_0000, 1'b0);
        wb(1'b0, 4'h0, 32'h0);
        check({28'h0, rd[31:28]}, 32'hd);
        // status shows the delayed fault, no result pulse by now
        wb(1'b0, fcu_pkg::STATUS_OFFSET, 32'h0);
        check(rd, 32'h2);
        wb(1'b1, 4'h0, 32'h0);
        wb(1'b0, 4'h0, 32'h0);
        check(rd, 32'h0);
        // sum mode keeps the highest exponent
        issue(3'h3, 32'h4ac0_0000, 1'b0);
        issue(3'h1, 32'h4000_0000, 1'b0);
        wb(1'b0, 4'h0, 32'h0);
        check({24'h0, rd[23:16]}, 32'h95);
        // product mode accumulates exponent minus bias
        wb(1'b1, 4'h0, 32'h0895_0000);
        issue(3'h1, 32'h4000_0000, 1'b0);
        issue(3'h2, 32'h4000_0000, 1'b0);
        wb(1'b0, 4'h0, 32'h0);
        check({24'h0, rd[23:16]}, 32'h97);
        // pass, conversion, pass back to back
        wb(1'b1, 4'h0, 32'h0);
        u_seq_model.prog_op = '{3'h1, 3'h2, 3'h1, 3'h0};
        u_seq_model.prog_a = '{32'h55, 32'h4ac0_0000, 32'haa, 32'h0};
        u_seq_model.prog_w = '{1'b0, 1'b1, 1'b0, 1'b0};
        fork
            u_seq_model.run(3);
            begin
                repeat (3) @(posedge MCLK);
                #1;
                check(U_BUS, 32'h55);
                check({31'h0, NO_INTERRUPT}, 32'h1);
                @(posedge MCLK);
                #1;
                check(U_BUS, 32'h0060_0000);
                check({31'h0, U_WIDE}, 32'h1);
                check({31'h0, U_VALID}, 32'h1);
            end
        join
        // software load of the U register while no op writes it
        wb(1'b1, fcu_pkg::OPERAND_OFFSET, 32'h1357_9bdf);
        wb(1'b0, fcu_pkg::OPERAND_OFFSET, 32'h0);
        check(rd, 32'h1357_9bdf);
        check(U_BUS, 32'h1357_9bdf);
        final_report();
    end
endmodule // tb_float_conversion_unit
